// ---- hw/scp_pkg.sv ----
package scp_pkg;

  // Register byte offsets on the AXI4-Lite bus.
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] TRIG_OFF = 8'h04;
  localparam logic [7:0] DATA_OFF = 8'h08;
  localparam logic [7:0] STAT_OFF = 8'h0C;

  // Bit positions in the trigger and status registers.
  localparam int unsigned TRIG_TX_BIT = 0;
  localparam int unsigned TRIG_RX_BIT = 1;
  localparam int unsigned STAT_TX_BIT = 0;
  localparam int unsigned STAT_RX_BIT = 1;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Control register layout, bit 7 down to bit 0.
  typedef struct packed {
    logic receive_enable;
    logic transmit_enable;
    logic parity_enable;
    logic clk_src_bit1;
    logic clk_src_bit0;
    logic mode_bit1;
    logic mode_bit0;
    logic serial_pin_enable;
  } scp_ctrl_t;

  localparam scp_ctrl_t CTRL_RESET = '0;

  // Pin pad drive; oe_n low means this block drives the pin.
  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe_n;
  } scp_pad_t;

  localparam scp_pad_t PAD_RESET = '{out: 4'h0, oe_n: 4'hF};

  // Pin order inside the four-pin group.
  localparam int unsigned PIN_SIN = 0;
  localparam int unsigned PIN_SERIAL_OUT = 1;
  localparam int unsigned PIN_SCLK = 2;
  localparam int unsigned PIN_RDY = 3;

  // Shift clock limits and the clock source dividers derived from them.
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned SCLK_MAX_HZ = 1_000_000;
  localparam int unsigned SCLK_DIV = 16;
  localparam int unsigned SRC_DIV_MIN = (CLK_HZ + SCLK_MAX_HZ * SCLK_DIV - 1) / (SCLK_MAX_HZ * SCLK_DIV);
  localparam logic [6:0] SRC_LAST0 = 7'(SRC_DIV_MIN - 1);
  localparam logic [6:0] SRC_LAST1 = 7'(SRC_DIV_MIN * 2 - 1);
  localparam logic [6:0] SRC_LAST2 = 7'(SRC_DIV_MIN * 4 - 1);
  localparam logic [6:0] SRC_LAST3 = 7'(SRC_DIV_MIN * 8 - 1);
  localparam logic [2:0] HALF_LAST = 3'(SCLK_DIV / 2 - 1);
  localparam logic [2:0] BIT_LAST = 3'h7;

  // Transfer engine states; the clock phases follow a Gray path.
  typedef enum logic [1:0] {
    SCP_IDLE = 2'b00,
    SCP_HIGH = 2'b01,
    SCP_LOW = 2'b11
  } scp_state_t;

endpackage

// ---- hw/scp_serial_port.sv ----
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

// How it works
// - Pins stay general I/O until pin enable set.
// - Mode bits 00 master, 01 slave.
// - Master clock from selected source; slave external.
// - Parity bit stored but never used here.
// - Master shift clock never exceeds 1 MHz.
// - Both enables zero resets the interface.
// - Transmit trigger starts master clock or waits.
// - One bit out per falling clock edge.
// - Output pin holds last bit afterwards.
// - End of transmit sets transmit done flag.
// - Receive trigger starts master clock or waits.
// - Input sampled on each rising clock edge.
// - Eighth rise stores byte, sets receive flag.
// - Slave ready pin low ready, high busy.
// - Ready falls on trigger, rises first falling.
// - Master mode leaves ready pin general I/O.
// - Master clock is source divided by sixteen.
// - Eight bits LSB first, half duplex only.
// - Trigger bits read one while busy.
module scp_serial_port (
  input wire logic clk, // 250 MHz system clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic [7:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [7:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire logic [3:0] pad_in, // Levels seen on the four pins.
  output scp_pkg::scp_pad_t pad, // Drive and enables for the four pins.
  input wire logic [3:0] port_out, // General port output levels.
  input wire logic [3:0] port_oe_n, // General port enables, low drives.
  output logic [3:0] port_in // Synchronised pin levels for the port.
);

  // Register state.
  scp_pkg::scp_ctrl_t ctrl;
  logic [7:0] tx_hold;
  logic [7:0] rx_buf;
  logic tx_done_flag;
  logic rx_done_flag;

  // Write channel holding state.
  logic aw_full;
  logic w_full;
  logic [7:0] aw_addr;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  // Transfer engine state.
  scp_pkg::scp_state_t state;
  scp_pkg::scp_state_t next_state;
  logic is_tx;
  logic [7:0] tx_shift;
  logic [7:0] rx_shift;
  logic [2:0] bit_cnt;
  logic [6:0] src_cnt;
  logic [2:0] half_cnt;
  logic serial_out;
  logic slave_ready_n;
  logic sclk_prev;

  // Register offset match on the word address.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a[7:2] == off[7:2];
  endfunction

  // Divider terminal count for the selected clock source.
  function automatic logic [6:0] src_last(input logic s1, input logic s0);
    logic [6:0] r;
    unique case ({s1, s0})
      2'b00: r = scp_pkg::SRC_LAST0;
      2'b01: r = scp_pkg::SRC_LAST1;
      2'b10: r = scp_pkg::SRC_LAST2;
      default: r = scp_pkg::SRC_LAST3;
    endcase
    return r;
  endfunction

  // Pin levels cross into the clock domain before anything reads them.
  scp_sync #(
    .W(4)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .d(pad_in),
    .q(port_in)
  );

  // Mode decode; an asynchronous mode selection leaves the engine idle.
  wire is_master = !ctrl.mode_bit1 && !ctrl.mode_bit0;
  wire is_slave = !ctrl.mode_bit1 && ctrl.mode_bit0;
  wire sync_mode = is_master || is_slave;
  wire link_off = !ctrl.transmit_enable && !ctrl.receive_enable;
  wire idle = state == scp_pkg::SCP_IDLE;
  wire sin_s = port_in[scp_pkg::PIN_SIN];
  wire sclk_s = port_in[scp_pkg::PIN_SCLK];

  // Write handshakes and the combined register write.
  wire aw_hs = s_axi_awvalid && s_axi_awready;
  wire w_hs = s_axi_wvalid && s_axi_wready;
  wire do_wr = aw_full && w_full && !s_axi_bvalid;
  wire wr_lane = do_wr && wstrb_q[0];
  wire wr_ctrl = wr_lane && hit(aw_addr, scp_pkg::CTRL_OFF);
  wire wr_trig = wr_lane && hit(aw_addr, scp_pkg::TRIG_OFF);
  wire wr_data = wr_lane && hit(aw_addr, scp_pkg::DATA_OFF);
  wire wr_stat = wr_lane && hit(aw_addr, scp_pkg::STAT_OFF);
  wire wr_ok = hit(aw_addr, scp_pkg::CTRL_OFF) || hit(aw_addr, scp_pkg::TRIG_OFF) ||
               hit(aw_addr, scp_pkg::DATA_OFF) || hit(aw_addr, scp_pkg::STAT_OFF);
  wire next_aw_full = do_wr ? 1'b0 : (aw_full || aw_hs);
  wire next_w_full = do_wr ? 1'b0 : (w_full || w_hs);
  wire next_bvalid = do_wr || (s_axi_bvalid && !s_axi_bready);

  // Read handshake and decode.
  wire ar_hs = s_axi_arvalid && s_axi_arready;
  wire next_rvalid = ar_hs || (s_axi_rvalid && !s_axi_rready);
  wire rd_ctrl = hit(s_axi_araddr, scp_pkg::CTRL_OFF);
  wire rd_trig = hit(s_axi_araddr, scp_pkg::TRIG_OFF);
  wire rd_data = hit(s_axi_araddr, scp_pkg::DATA_OFF);
  wire rd_stat = hit(s_axi_araddr, scp_pkg::STAT_OFF);
  wire rd_ok = rd_ctrl || rd_trig || rd_data || rd_stat;

  // Triggers start a transfer only when idle, so transmit and receive never overlap;
  // transmit wins if software writes both bits at once.
  wire trig_tx = wdata_q[scp_pkg::TRIG_TX_BIT];
  wire trig_rx = wdata_q[scp_pkg::TRIG_RX_BIT];
  wire can_start = wr_trig && idle && sync_mode && ctrl.serial_pin_enable;
  wire start_tx = can_start && trig_tx && ctrl.transmit_enable;
  wire start_rx = can_start && !trig_tx && trig_rx && ctrl.receive_enable;
  wire start = start_tx || start_rx;

  // Clock source and the divide by sixteen that forms the master shift clock.
  wire tick = src_cnt == src_last(ctrl.clk_src_bit1, ctrl.clk_src_bit0);
  wire half_done = tick && half_cnt == scp_pkg::HALF_LAST;

  // Shift clock edges, generated in master mode, detected in slave mode.
  wire sclk_fall = sclk_prev && !sclk_s;
  wire sclk_rise = !sclk_prev && sclk_s;
  wire ev_fall = state == scp_pkg::SCP_HIGH && (is_master ? half_done : sclk_fall);
  wire ev_rise = state == scp_pkg::SCP_LOW && (is_master ? half_done : sclk_rise);
  wire last_rise = ev_rise && bit_cnt == scp_pkg::BIT_LAST;
  wire [7:0] rx_next = {sin_s, rx_shift[7:1]};

  // Completion events; parity_enable is never consulted on this path.
  wire tx_set = last_rise && is_tx;
  wire rx_set = last_rise && !is_tx;
  wire tx_clr = wr_stat && wdata_q[scp_pkg::STAT_TX_BIT];
  wire rx_clr = wr_stat && wdata_q[scp_pkg::STAT_RX_BIT];
  wire tx_busy = !idle && is_tx;
  wire rx_busy = !idle && !is_tx;

  // Read data words.
  wire [31:0] trig_word = (32'(tx_busy) << scp_pkg::TRIG_TX_BIT) | (32'(rx_busy) << scp_pkg::TRIG_RX_BIT);
  wire [31:0] stat_word = (32'(tx_done_flag) << scp_pkg::STAT_TX_BIT) |
                          (32'(rx_done_flag) << scp_pkg::STAT_RX_BIT);
  wire [31:0] rd_word = rd_ctrl ? {24'h0, ctrl} :
                        rd_trig ? trig_word :
                        rd_data ? {24'h0, rx_buf} :
                        rd_stat ? stat_word : 32'h0;

  // Pin muxing: each pin falls back to the general port unless serial use claims it.
  wire pin_en = ctrl.serial_pin_enable;
  wire own_sclk = pin_en && sync_mode;
  wire own_rdy = pin_en && is_slave;
  wire sclk_level = state != scp_pkg::SCP_LOW;
  scp_pkg::scp_pad_t next_pad;
  assign next_pad.out[scp_pkg::PIN_SIN] = port_out[scp_pkg::PIN_SIN];
  assign next_pad.oe_n[scp_pkg::PIN_SIN] = pin_en || port_oe_n[scp_pkg::PIN_SIN];
  assign next_pad.out[scp_pkg::PIN_SERIAL_OUT] = pin_en ? serial_out : port_out[scp_pkg::PIN_SERIAL_OUT];
  assign next_pad.oe_n[scp_pkg::PIN_SERIAL_OUT] = pin_en ? 1'b0 : port_oe_n[scp_pkg::PIN_SERIAL_OUT];
  assign next_pad.out[scp_pkg::PIN_SCLK] = own_sclk ? sclk_level : port_out[scp_pkg::PIN_SCLK];
  assign next_pad.oe_n[scp_pkg::PIN_SCLK] = own_sclk ? !is_master : port_oe_n[scp_pkg::PIN_SCLK];
  assign next_pad.out[scp_pkg::PIN_RDY] = own_rdy ? slave_ready_n : port_out[scp_pkg::PIN_RDY];
  assign next_pad.oe_n[scp_pkg::PIN_RDY] = own_rdy ? 1'b0 : port_oe_n[scp_pkg::PIN_RDY];

  // Engine sequencing; clearing both enables drops any transfer at once.
  always_comb begin
    next_state = state;
    unique case (state)
      scp_pkg::SCP_IDLE: begin
        if (start) begin
          next_state = scp_pkg::SCP_HIGH;
        end
      end
      scp_pkg::SCP_HIGH: begin
        if (ev_fall) begin
          next_state = scp_pkg::SCP_LOW;
        end
      end
      scp_pkg::SCP_LOW: begin
        if (last_rise) begin
          next_state = scp_pkg::SCP_IDLE;
        end else if (ev_rise) begin
          next_state = scp_pkg::SCP_HIGH;
        end
      end
      default: begin
        next_state = scp_pkg::SCP_IDLE;
      end
    endcase
    if (link_off) begin
      next_state = scp_pkg::SCP_IDLE;
    end
  end

  // AXI write channel; address and data may arrive in either order.
  always_ff @(posedge clk) begin
    if (rst) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= scp_pkg::RESP_OKAY;
    end else begin
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      s_axi_awready <= !next_aw_full;
      s_axi_wready <= !next_w_full;
      s_axi_bvalid <= next_bvalid;
      if (do_wr) begin
        s_axi_bresp <= wr_ok ? scp_pkg::RESP_OKAY : scp_pkg::RESP_SLVERR;
      end
    end
  end

  // Captured write payloads; no reset needed as they are qualified by the full flags.
  always_ff @(posedge clk) begin
    if (aw_hs) begin
      aw_addr <= s_axi_awaddr;
    end
    if (w_hs) begin
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end
  end

  // AXI read channel; the answer is registered one cycle after the address.
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= scp_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !next_rvalid;
      s_axi_rvalid <= next_rvalid;
      if (ar_hs) begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? scp_pkg::RESP_OKAY : scp_pkg::RESP_SLVERR;
      end
    end
  end

  // Control and transmit data registers.
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl <= scp_pkg::CTRL_RESET;
      tx_hold <= 8'h00;
    end else begin
      if (wr_ctrl) begin
        ctrl <= scp_pkg::scp_ctrl_t'(wdata_q[7:0]);
      end
      if (wr_data) begin
        tx_hold <= wdata_q[7:0];
      end
    end
  end

  // Done flags: a completion in the same cycle as a clear still sets the flag.
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_done_flag <= 1'b0;
      rx_done_flag <= 1'b0;
    end else begin
      tx_done_flag <= tx_set || (tx_done_flag && !tx_clr);
      rx_done_flag <= rx_set || (rx_done_flag && !rx_clr);
    end
  end

  // Source divider and half-period counter restart on a trigger for a full first phase.
  always_ff @(posedge clk) begin
    if (rst || start || tick) begin
      src_cnt <= 7'h00;
    end else begin
      src_cnt <= src_cnt + 7'h01;
    end
    if (rst || start || half_done) begin
      half_cnt <= 3'h0;
    end else if (tick) begin
      half_cnt <= half_cnt + 3'h1;
    end
  end

  // State, direction, bit count and slave clock edge history.
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= scp_pkg::SCP_IDLE;
      is_tx <= 1'b0;
      bit_cnt <= 3'h0;
      sclk_prev <= 1'b1;
    end else begin
      state <= next_state;
      sclk_prev <= sclk_s;
      if (start) begin
        is_tx <= start_tx;
        bit_cnt <= 3'h0;
      end else if (ev_rise) begin
        bit_cnt <= bit_cnt + 3'h1;
      end
    end
  end

  // Shift registers; the output pin keeps the last bit until the next transmit.
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_shift <= 8'h00;
      rx_shift <= 8'h00;
      rx_buf <= 8'h00;
      serial_out <= 1'b1;
    end else begin
      if (start_tx) begin
        tx_shift <= tx_hold;
      end else if (ev_fall && is_tx) begin
        serial_out <= tx_shift[0];
        tx_shift <= tx_shift >> 1;
      end
      if (ev_rise && !is_tx) begin
        rx_shift <= rx_next;
      end
      if (rx_set) begin
        rx_buf <= rx_next;
      end
    end
  end

  // Slave ready: low from trigger until the first falling clock edge, high otherwise.
  always_ff @(posedge clk) begin
    if (rst || link_off || ev_fall) begin
      slave_ready_n <= 1'b1;
    end else if (start && is_slave) begin
      slave_ready_n <= 1'b0;
    end
  end

  // Pin drive is registered so every pad output comes from a flop.
  always_ff @(posedge clk) begin
    if (rst) begin
      pad <= scp_pkg::PAD_RESET;
    end else begin
      pad <= next_pad;
    end
  end

endmodule

// ---- hw/scp_sync.sv ----
`timescale 1ns/1ps

// Two-flop synchroniser for levels arriving from the pins.
module scp_sync #(
  parameter int unsigned W = 4
) (
  input wire logic clk, // System clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic [W-1:0] d, // Asynchronous input levels.
  output logic [W-1:0] q // Synchronised levels.
);

  logic [W-1:0] meta;

  // The first stage feeds only the second, so metastability cannot spread.
  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

// ---- test/scp_far_end.sv ----
`timescale 1ns/1ps

// External serial device: slave to the block's clock, or master with a clock of its own.
module scp_far_end (
  input wire logic clk, // Time base.
  input wire scp_pkg::scp_pad_t pad, // Block pin drive.
  output logic sin_level, // Level put on serial_in.
  output logic sclk_level, // Clock when the block is slave, high when idle.
  output logic [7:0] got // Byte taken from serial_out.
);
  localparam int HALF = 130; // Half period of 520 ns keeps the clock below 1 MHz.
  logic [7:0] send;
  logic [3:0] nbit;

  initial begin
    send = 8'h00;
    nbit = 4'h0;
    got = 8'h00;
    sin_level = 1'b1;
    sclk_level = 1'b1;
  end

  // Slave role: new bit on each fall, capture on each rise; the line flips once the frame ends.
  always @(posedge clk) begin
    if (!pad.oe_n[2] && $changed(pad.out[2])) begin
      if (!pad.out[2]) begin
        sin_level <= send[nbit[2:0]];
      end else begin
        got <= {pad.out[1], got[7:1]};
        nbit <= nbit + 4'h1;
        if (nbit == 4'h7) sin_level <= ~send[7];
      end
    end
  end

  task automatic load(input logic [7:0] b);
    send = b;
    nbit = 4'h0;
  endtask

  // Master role: wait until the block reports ready, then clock eight bits.
  task automatic frame(input logic [7:0] b);
    while (pad.out[3] !== 1'b0) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      sclk_level <= 1'b0;
      sin_level <= b[i];
      repeat (HALF) @(posedge clk);
      sclk_level <= 1'b1;
      got <= {pad.out[1], got[7:1]};
      repeat (HALF) @(posedge clk);
    end
    sin_level <= ~b[7];
  endtask
endmodule

// ---- test/scp_serial_port_bench.sv ----
`timescale 1ns/1ps

// Bus tasks, one task per scenario, and the far-end model on the pins.
module scp_serial_port_bench;
  localparam logic [1:0] OK = scp_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = scp_pkg::RESP_SLVERR;
  logic clk = 1'b0, rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb = 4'hF, port_out = 4'h0, port_oe_n = 4'hF, pad_in, port_in;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, sin_level, sclk_level;
  logic [1:0] s_axi_bresp, s_axi_rresp, rrsp;
  logic [7:0] got;
  scp_pkg::scp_pad_t pad;
  int miscompares = 0, n_compared = 0;

  scp_serial_port u_dut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pad_in, .pad, .port_out,
    .port_oe_n, .port_in);
  scp_far_end u_far (.clk, .pad, .sin_level, .sclk_level, .got);

  // Serial output and ready lines have pull-ups, so an undriven pin reads high.
  assign pad_in = {pad.oe_n[3] ? 1'b1 : pad.out[3], pad.oe_n[2] ? sclk_level : pad.out[2],
    pad.oe_n[1] ? 1'b1 : pad.out[1], pad.oe_n[0] ? sin_level : pad.out[0]};

  always #2 clk = ~clk;

  task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [31:0] ctrl(input logic m0, input logic [1:0] src, input logic par, tx, rx);
    scp_pkg::scp_ctrl_t c;
    c = '{rx, tx, par, src[1], src[0], 1'b0, m0, 1'b1};
    return {24'h000000, c};
  endfunction

  // Address and data go out together; each is released at its own handshake.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // No local limit: only the watchdog may end a wait for the answer.
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    check("write answer", {s_axi_bvalid, s_axi_bresp}, {1'b1, er});
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rdat = s_axi_rdata;
    rrsp = s_axi_rresp;
  endtask

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    rd(a);
    check(what, {rrsp, rdat}, {er, exp});
  endtask

  task automatic poll(input logic [31:0] m);
    int n;
    n = 0;
    do begin
      rd(scp_pkg::STAT_OFF);
      n++;
    end while ((rdat & m) == 32'h0 && n < 8000);
    check("done flag", rdat & m, m);
  endtask

  task automatic wait_pin(input int i, input logic v, output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pad_in[i] !== v && n < 5000);
  endtask

  task automatic t_port();
    @(posedge clk);
    port_oe_n <= 4'h5;
    repeat (4) @(posedge clk);
    check("pad enables", pad.oe_n, 4'h5);
    check("pad levels", pad.out, 4'h0);
    check("port levels", port_in, 4'h5);
    port_oe_n <= 4'hF;
    rdc("ctrl reset", scp_pkg::CTRL_OFF, 32'h0, OK);
    rdc("unmapped read", 8'h10, 32'h0, ERR);
    wr(8'h10, 32'hFF, ERR);
    wr(scp_pkg::TRIG_OFF, 32'h1, OK);
    rdc("trigger ignored", scp_pkg::TRIG_OFF, 32'h0, OK);
    // An asynchronous mode selection must neither start a transfer nor claim the clock pin.
    wr(scp_pkg::CTRL_OFF, 32'h45, OK);
    wr(scp_pkg::TRIG_OFF, 32'h1, OK);
    rdc("async mode idle", scp_pkg::TRIG_OFF, 32'h0, OK);
    check("async clock pin", pad.oe_n[2], 1'b1);
  endtask

  task automatic t_master_tx();
    logic [7:0] b;
    int n1, n2;
    for (int s = 0; s < 4; s++) begin
      b = 8'hA5 ^ 8'(s * 60);
      u_far.load(~b);
      wr(scp_pkg::CTRL_OFF, 32'h0, OK);
      wr(scp_pkg::CTRL_OFF, ctrl(1'b0, 2'(s), s == 1, 1'b1, 1'b0), OK);
      wr(scp_pkg::DATA_OFF, {24'h0, b}, OK);
      check("clock idle", pad_in[2], 1'b1);
      check("ready pin free", pad.oe_n[3], 1'b1);
      wr(scp_pkg::TRIG_OFF, 32'h1, OK);
      rdc("tx busy", scp_pkg::TRIG_OFF, 32'h1, OK);
      wait_pin(2, 1'b0, n1);
      wait_pin(2, 1'b1, n1);
      wait_pin(2, 1'b0, n2);
      check("shift period", 36'(n1 + n2), 36'((scp_pkg::SRC_DIV_MIN * scp_pkg::SCLK_DIV) << s));
      poll(32'h1);
      check("tx byte", got, b);
      check("last bit held", pad.out[1], b[7]);
      rdc("tx stopped", scp_pkg::TRIG_OFF, 32'h0, OK);
      wr(scp_pkg::STAT_OFF, 32'h1, OK);
      rdc("flag cleared", scp_pkg::STAT_OFF, 32'h0, OK);
    end
  endtask

  task automatic t_master_rx();
    logic [7:0] b;
    wr(scp_pkg::CTRL_OFF, ctrl(1'b0, 2'b00, 1'b0, 1'b0, 1'b1), OK);
    for (int k = 0; k < 2; k++) begin
      b = k ? 8'h3C : 8'h81;
      u_far.load(b);
      wr(scp_pkg::TRIG_OFF, 32'h2, OK);
      rdc("rx busy", scp_pkg::TRIG_OFF, 32'h2, OK);
      poll(32'h2);
      rdc("rx byte", scp_pkg::DATA_OFF, {24'h0, b}, OK);
      check("clock idle", pad_in[2], 1'b1);
      wr(scp_pkg::STAT_OFF, 32'h2, OK);
    end
  endtask

  task automatic t_abort();
    int n;
    u_far.load(8'h00);
    wr(scp_pkg::CTRL_OFF, ctrl(1'b0, 2'b00, 1'b0, 1'b1, 1'b1), OK);
    wr(scp_pkg::TRIG_OFF, 32'h3, OK);
    rdc("one direction", scp_pkg::TRIG_OFF, 32'h1, OK);
    wait_pin(2, 1'b0, n);
    repeat (140) @(posedge clk);
    wr(scp_pkg::CTRL_OFF, ctrl(1'b0, 2'b00, 1'b0, 1'b0, 1'b0), OK);
    rdc("aborted", scp_pkg::TRIG_OFF, 32'h0, OK);
    check("clock released", pad_in[2], 1'b1);
    rdc("no flag", scp_pkg::STAT_OFF, 32'h0, OK);
  endtask

  task automatic t_slave();
    wr(scp_pkg::CTRL_OFF, ctrl(1'b1, 2'b11, 1'b0, 1'b1, 1'b0), OK);
    wr(scp_pkg::DATA_OFF, 32'h96, OK);
    check("clock pin input", pad.oe_n[2], 1'b1);
    wr(scp_pkg::TRIG_OFF, 32'h1, OK);
    repeat (3) @(posedge clk);
    check("slave ready", pad_in[3], 1'b0);
    u_far.frame(8'h00);
    check("slave busy", pad_in[3], 1'b1);
    check("slave tx byte", got, 8'h96);
    poll(32'h1);
    wr(scp_pkg::STAT_OFF, 32'h1, OK);
    wr(scp_pkg::CTRL_OFF, ctrl(1'b1, 2'b00, 1'b0, 1'b0, 1'b1), OK);
    wr(scp_pkg::TRIG_OFF, 32'h2, OK);
    u_far.frame(8'h4B);
    poll(32'h2);
    rdc("slave rx byte", scp_pkg::DATA_OFF, 32'h4B, OK);
  endtask

  task automatic end_of_test();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Main sequence after a five-cycle reset.
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_port();
    t_master_tx();
    t_master_rx();
    t_abort();
    t_slave();
    end_of_test();
  end

  // Watchdog sized at about twice the expected run of some 40000 cycles.
  initial begin
    repeat (90000) @(posedge clk);
    miscompares++;
    end_of_test();
  end
endmodule

// ---- test/scp_serial_port_properties.sv ----
`timescale 1ns/1ps

// Pin and bus timing, watched from the top module's ports only.
module scp_serial_port_checker (
  input wire logic clk, // System clock.
  input wire logic rst, // Synchronous reset.
  input wire logic s_axi_awvalid, // Write address valid.
  input wire logic s_axi_awready, // Write address ready.
  input wire logic s_axi_wvalid, // Write data valid.
  input wire logic s_axi_wready, // Write data ready.
  input wire logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_arvalid, // Read address valid.
  input wire logic s_axi_arready, // Read address ready.
  input wire logic s_axi_rvalid, // Read data valid.
  input wire logic [3:0] pad_in, // Resolved pin levels.
  input wire scp_pkg::scp_pad_t pad // Pin drive.
);
  localparam int HALF_MIN = scp_pkg::SRC_DIV_MIN * scp_pkg::SCLK_DIV / 2 - 1;
  logic [7:0] held;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Cycles since the clock pin last moved; it saturates so long idle spans never wrap to a small count.
  always_ff @(posedge clk) begin
    if (rst) begin
      held <= 8'hFF;
    end else if ($changed(pad.out[2])) begin
      held <= 8'h00;
    end else if (held != 8'hFF) begin
      held <= held + 8'h01;
    end
  end

  chk_clk_half: assert property (!pad.oe_n[2] && !$past(pad.oe_n[2]) && $changed(pad.out[2])
    |-> held >= HALF_MIN)
    else $error("shift clock half period too short");
  chk_idle_high: assert property ($fell(pad.oe_n[2]) |-> pad.out[2])
    else $error("clock pin taken over at low level");
  chk_out_on_fall: assert property (!pad.oe_n[1] && !$past(pad.oe_n[1]) && $changed(pad.out[1])
    |-> ##[0:2] !pad_in[2])
    else $error("serial output moved while the clock was high");
  chk_ready_free: assert property (!pad.oe_n[3] && !$past(pad.oe_n[3]) && $rose(pad.out[3]) |-> !pad_in[2])
    else $error("ready line went busy without a clock fall");
  chk_ready_taken: assert property (!pad.oe_n[3] && !$past(pad.oe_n[3]) && $fell(pad.out[3])
    |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("ready line went low without a register write");
  chk_master_ready: assert property (!pad.oe_n[2] |-> pad.oe_n[3])
    else $error("ready pin driven while clock pin is driven");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer not one cycle after address");
  // The write is applied one edge after both handshakes, so the answer shows two cycles later.
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write answer not two cycles after address and data");
endmodule

bind scp_serial_port scp_serial_port_checker u_chk (.clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .pad_in, .pad);
